// ### pfdrb_pkg.sv
// pfdrb_pkg: offsets, field positions and reset values of the pfd register bank
// assumes a 30-bit data / 7-bit address serial frame decoded elsewhere
package pfdrb_pkg;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 32;
	localparam logic [6:0] REG_ID_RST_RA = 7'h00;
	localparam logic [6:0] REG_BLOCK_EN = 7'h01;
	localparam logic [6:0] REG_REF_DIV = 7'h02;
	localparam logic [6:0] REG_DET_SET = 7'h03;
	// register zero fields
	localparam int unsigned RA_LSB = 0;
	localparam int unsigned RA_W = 7;
	localparam int unsigned SRST_BIT = 7;
	localparam int unsigned ID_LSB = 8;
	localparam int unsigned ID_W = 24;
	// block enable fields
	localparam int unsigned EN_W = 20;
	localparam logic [19:0] EN_RST = 20'h3_fffe;
	localparam int unsigned EN_SRC_BIT = 0;
	localparam int unsigned EN_SPI_CE_BIT = 1;
	localparam int unsigned EN_RDIV_BIT = 2;
	localparam int unsigned EN_PFD_BIT = 3;
	localparam int unsigned EN_SLIP_BIT = 4;
	localparam int unsigned EN_CP_BIT = 5;
	localparam int unsigned EN_LD_BIT = 6;
	localparam int unsigned EN_WDOG_BIT = 7;
	localparam int unsigned EN_OS_LD_BIT = 8;
	localparam int unsigned EN_GPO_BIT = 9;
	localparam int unsigned EN_REFBUF_BIT = 10;
	localparam int unsigned EN_TCLK_BIT = 11;
	localparam int unsigned EN_BIAS_BIT = 12;
	localparam int unsigned EN_SLIP_OUT_BIT = 13;
	localparam int unsigned EN_OPAMP_BIT = 14;
	localparam int unsigned EN_DIVTCLK_BIT = 18;
	// reference divider
	localparam int unsigned RDIV_W = 14;
	localparam logic [13:0] RDIV_RST = 14'h0001;
	// detector settings
	localparam int unsigned DS_W = 12;
	localparam logic [11:0] DS_RST = 12'h0_ccc;
	localparam int unsigned DS_DLY_LSB = 0;
	localparam int unsigned DS_DLY_W = 3;
	localparam int unsigned DS_AUTO_BIT = 3;
	localparam int unsigned DS_SWAP_BIT = 4;
	localparam int unsigned DS_SHORT_BIT = 5;
	localparam int unsigned DS_UPEN_BIT = 6;
	localparam int unsigned DS_DNEN_BIT = 7;
	localparam int unsigned DS_FUP_BIT = 8;
	localparam int unsigned DS_FDN_BIT = 9;
	localparam int unsigned DS_TOLD_BIT = 10;
	localparam int unsigned DS_XRST_BIT = 11;
	// watchdog: reference-divider cycles without detector pulses
	localparam int unsigned WDOG_W = 8;
	localparam logic [7:0] WDOG_LIMIT = 8'hff;
endpackage : pfdrb_pkg

// ### pfdrb_ref_div.sv
// pfdrb_ref_div: reference divider producing a one-cycle enable pulse
// assumes ratio is stable between writes; ratio 0 treated as 1
`timescale 1ns/1ps
module pfdrb_ref_div #(
	parameter int unsigned W = 14
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic enable_in,
	input wire logic [W-1:0] ratio_in,
	output logic tick_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;
	assign tick_out = tick_r;
	always_comb begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (enable_in) begin
			// wrap at ratio-1, so ratio 1 pulses every cycle
			if (cnt_r + W'(1) >= ratio_in) begin
				cnt_nxt = '0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + W'(1);
			end
		end else begin
			cnt_nxt = '0;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
endmodule : pfdrb_ref_div

// ### pfdrb_bank.sv
// pfdrb_bank: configuration registers 0..3 of the phase-frequency detector
// assumes a serial shifter delivers decoded one-cycle write/read strobes
`timescale 1ns/1ps
module pfdrb_bank
	import pfdrb_pkg::*;
#(
	parameter logic [23:0] CHIP_ID = 24'h00_0a5c, // arbitrary value
	parameter int unsigned RDIV_BITS = RDIV_W
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic wr_stb_in,
	input wire logic [ADDR_W-1:0] wr_addr_in,
	input wire logic [29:0] wr_data_in,
	input wire logic rd_stb_in,
	input wire logic chip_enable_pin_in,
	input wire logic ref_in,
	input wire logic div_in,
	input wire logic det_up_in,
	input wire logic det_dn_in,
	input wire logic xtal_export_in,
	input wire logic gpo_data_in,
	output logic [DATA_W-1:0] rd_data_out,
	output logic chip_en_out,
	output logic ref_tick_out,
	output logic det_ref_out,
	output logic det_div_out,
	output logic det_rst_out,
	output logic det_up_out,
	output logic det_dn_out,
	output logic ld_up_out,
	output logic ld_dn_out,
	output logic slip_prevention_out,
	output logic slip_prevention_oe_out,
	output logic cp_en_out,
	output logic lock_indicator_out,
	output logic oneshot_ld_en_out,
	output logic general_purpose_pin_out,
	output logic general_purpose_pin_oe_out,
	output logic test_clk_en_out,
	output logic div_test_clk_en_out,
	output logic [EN_W-1:0] enables_out
);
	logic [RA_W-1:0] ra_r, ra_nxt;
	logic srst_r, srst_nxt;
	logic [EN_W-1:0] en_r, en_nxt;
	logic [RDIV_BITS-1:0] rdiv_r, rdiv_nxt;
	logic [DS_W-1:0] ds_r, ds_nxt;
	logic [DATA_W-1:0] rd_r, rd_nxt;
	logic [WDOG_W-1:0] wd_r, wd_nxt;
	logic lock_r, lock_nxt;
	logic [DS_DLY_W-1:0] sat_r, sat_nxt;
	logic sat_on_r, sat_on_nxt;
	logic [14:0] out_r, out_nxt;
	logic tick;
	logic chip_en;
	logic up_n, dn_n;
	logic rst_all;

	function automatic logic [DATA_W-1:0] reg_view(input logic [6:0] a,
		input logic [RA_W-1:0] ra, input logic sr, input logic [EN_W-1:0] en,
		input logic [RDIV_BITS-1:0] rd, input logic [DS_W-1:0] ds);
		case (a)
			REG_ID_RST_RA: reg_view = {CHIP_ID, sr, ra};
			REG_BLOCK_EN: reg_view = DATA_W'(en);
			REG_REF_DIV: reg_view = DATA_W'(rd);
			REG_DET_SET: reg_view = DATA_W'(ds);
			default: reg_view = '0;
		endcase
	endfunction : reg_view

	// soft reset held while bit set, acts as a synchronous reset
	assign rst_all = sys_rst_in | srst_r;

	always_comb begin
		ra_nxt = ra_r;
		srst_nxt = srst_r;
		en_nxt = en_r;
		rdiv_nxt = rdiv_r;
		ds_nxt = ds_r;
		rd_nxt = rd_r;
		if (wr_stb_in) begin
			case (wr_addr_in)
				REG_ID_RST_RA: begin
					ra_nxt = wr_data_in[RA_LSB +: RA_W];
					srst_nxt = wr_data_in[SRST_BIT];
				end
				REG_BLOCK_EN: en_nxt = wr_data_in[EN_W-1:0];
				REG_REF_DIV: rdiv_nxt = wr_data_in[RDIV_BITS-1:0];
				REG_DET_SET: ds_nxt = wr_data_in[DS_W-1:0];
				default: ;
			endcase
		end
		// read image latched at start of the frame after the address write
		if (rd_stb_in) begin
			rd_nxt = reg_view(ra_r, ra_r, srst_r, en_r, rdiv_r, ds_r);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			srst_r <= 1'b0;
			ra_r <= '0;
			en_r <= EN_RST;
			rdiv_r <= RDIV_BITS'(RDIV_RST);
			ds_r <= DS_RST;
			rd_r <= '0;
		end else if (srst_r) begin
			// registers held at defaults; only the soft reset bit may clear
			srst_r <= srst_nxt;
			ra_r <= '0;
			en_r <= EN_RST;
			rdiv_r <= RDIV_BITS'(RDIV_RST);
			ds_r <= DS_RST;
			rd_r <= '0;
		end else begin
			srst_r <= srst_nxt;
			ra_r <= ra_nxt;
			en_r <= en_nxt;
			rdiv_r <= rdiv_nxt;
			ds_r <= ds_nxt;
			rd_r <= rd_nxt;
		end
	end

	pfdrb_ref_div #(
		.W(RDIV_BITS)
	) u_div (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(rst_all),
		.enable_in(chip_en & en_r[EN_RDIV_BIT]),
		.ratio_in(rdiv_r),
		.tick_out(tick)
	);

	assign chip_en = en_r[EN_SRC_BIT] ? en_r[EN_SPI_CE_BIT] :
		chip_enable_pin_in;

	// detector path, swap then short, then enables and forces
	always_comb begin
		logic a, b, pfd_on;
		pfd_on = chip_en & en_r[EN_PFD_BIT] &
			~(ds_r[DS_XRST_BIT] & xtal_export_in);
		a = ds_r[DS_SWAP_BIT] ? div_in : ref_in;
		b = ds_r[DS_SWAP_BIT] ? ref_in : div_in;
		if (ds_r[DS_SHORT_BIT]) begin
			b = a;
		end
		up_n = ds_r[DS_FUP_BIT] |
			(pfd_on & ds_r[DS_UPEN_BIT] & det_up_in);
		dn_n = ds_r[DS_FDN_BIT] |
			(pfd_on & ds_r[DS_DNEN_BIT] & det_dn_in);
		out_nxt[0] = a;
		out_nxt[1] = b;
		out_nxt[2] = ~pfd_on;
		out_nxt[3] = up_n;
		out_nxt[4] = dn_n;
		out_nxt[5] = ds_r[DS_TOLD_BIT] & up_n;
		out_nxt[6] = ds_r[DS_TOLD_BIT] & dn_n;
		out_nxt[7] = chip_en & en_r[EN_SLIP_BIT] & sat_on_r;
		out_nxt[8] = en_r[EN_SLIP_OUT_BIT];
		out_nxt[9] = chip_en & en_r[EN_CP_BIT];
		out_nxt[10] = chip_en & en_r[EN_OS_LD_BIT];
		out_nxt[11] = en_r[EN_GPO_BIT];
		out_nxt[12] = en_r[EN_TCLK_BIT];
		out_nxt[13] = en_r[EN_DIVTCLK_BIT];
		out_nxt[14] = chip_en & en_r[EN_LD_BIT];
	end

	// watchdog counts reference ticks since last pulse; lock drops at limit
	always_comb begin
		wd_nxt = wd_r;
		lock_nxt = lock_r;
		if (!out_r[14]) begin
			wd_nxt = '0;
			lock_nxt = 1'b0;
		end else if (out_r[5] | out_r[6]) begin
			wd_nxt = '0;
			lock_nxt = 1'b1;
		end else if (tick && en_r[EN_WDOG_BIT]) begin
			if (wd_r == WDOG_LIMIT) begin
				lock_nxt = 1'b0;
			end else begin
				wd_nxt = wd_r + WDOG_W'(1);
			end
		end
	end

	// saturation detect re-arms after the programmed tick count
	always_comb begin
		sat_nxt = sat_r;
		sat_on_nxt = sat_on_r;
		if (ds_r[DS_AUTO_BIT] && lock_r) begin
			sat_on_nxt = 1'b0;
			sat_nxt = '0;
		end else if (tick) begin
			if (sat_r == ds_r[DS_DLY_LSB +: DS_DLY_W]) begin
				sat_nxt = '0;
				sat_on_nxt = 1'b1;
			end else begin
				sat_nxt = sat_r + DS_DLY_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			wd_r <= '0;
			lock_r <= 1'b0;
			sat_r <= '0;
			sat_on_r <= 1'b0;
			out_r <= '0;
		end else begin
			wd_r <= wd_nxt;
			lock_r <= lock_nxt;
			sat_r <= sat_nxt;
			sat_on_r <= sat_on_nxt;
			out_r <= out_nxt;
		end
	end

	logic chip_en_r, tick_r, gp_r;
	always_ff @(posedge ref_clk_in) begin
		// soft reset clears these too, all digital state but the soft reset bit restarts
		if (rst_all) begin
			chip_en_r <= 1'b0;
			tick_r <= 1'b0;
			gp_r <= 1'b0;
		end else begin
			chip_en_r <= chip_en;
			tick_r <= tick;
			gp_r <= lock_r & gpo_data_in;
		end
	end

	assign rd_data_out = rd_r;
	assign chip_en_out = chip_en_r;
	assign ref_tick_out = tick_r;
	assign det_ref_out = out_r[0];
	assign det_div_out = out_r[1];
	assign det_rst_out = out_r[2];
	assign det_up_out = out_r[3];
	assign det_dn_out = out_r[4];
	assign ld_up_out = out_r[5];
	assign ld_dn_out = out_r[6];
	assign slip_prevention_out = out_r[7];
	assign slip_prevention_oe_out = out_r[8];
	assign cp_en_out = out_r[9];
	assign oneshot_ld_en_out = out_r[10];
	assign general_purpose_pin_oe_out = out_r[11];
	assign test_clk_en_out = out_r[12];
	assign div_test_clk_en_out = out_r[13];
	assign lock_indicator_out = lock_r;
	assign general_purpose_pin_out = gp_r;
	assign enables_out = en_r;

	a_srst_defaults: assert property (@(posedge ref_clk_in) disable iff
		(sys_rst_in) srst_r |=> en_r == EN_RST && ds_r == DS_RST)
		else $error("soft reset did not restore defaults");
	a_rd_id: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		rd_stb_in && ra_r == REG_ID_RST_RA && !srst_r
		|=> rd_r[ID_LSB +: ID_W] == CHIP_ID)
		else $error("id not returned");
	a_ce_source: assert property (@(posedge ref_clk_in) disable iff
		(rst_all) en_r[EN_SRC_BIT]
		|=> chip_en_r == $past(en_r[EN_SPI_CE_BIT]))
		else $error("serial enable not selected");
	a_force_up: assert property (@(posedge ref_clk_in) disable iff
		(rst_all) ds_r[DS_FUP_BIT] |=> det_up_out)
		else $error("forced up not asserted");
	a_up_gate: assert property (@(posedge ref_clk_in) disable iff (rst_all)
		!ds_r[DS_UPEN_BIT] && !ds_r[DS_FUP_BIT] |=> !det_up_out)
		else $error("up not suppressed");
	a_short_mode: assert property (@(posedge ref_clk_in) disable iff
		(rst_all) ds_r[DS_SHORT_BIT] |=> det_ref_out == det_div_out)
		else $error("short mode inputs differ");
	a_gpo_dir: assert property (@(posedge ref_clk_in) disable iff (rst_all)
		1'b1 |=> general_purpose_pin_oe_out == $past(en_r[EN_GPO_BIT]))
		else $error("gpo direction wrong");
	a_xtal_rst: assert property (@(posedge ref_clk_in) disable iff (rst_all)
		ds_r[DS_XRST_BIT] && xtal_export_in |=> det_rst_out)
		else $error("detector not reset");
	a_ld_route: assert property (@(posedge ref_clk_in) disable iff (rst_all)
		!ds_r[DS_TOLD_BIT] |=> !ld_up_out && !ld_dn_out)
		else $error("ld routing not blocked");
	c_soft_reset: cover property (@(posedge ref_clk_in) srst_r ##1 !srst_r);
	c_read_back: cover property (@(posedge ref_clk_in) rd_stb_in);
	c_lock: cover property (@(posedge ref_clk_in) !lock_r ##1 lock_r);
endmodule : pfdrb_bank

// ### pfdrb_host.sv
// pfdrb_host: host model issuing decoded register strobes to the bank
// assumes writes are taken on the rising edge, read image one edge later
`timescale 1ns/1ps
module pfdrb_host
	import pfdrb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic [DATA_W-1:0] rd_data_in,
	output logic wr_stb_out,
	output logic [ADDR_W-1:0] wr_addr_out,
	output logic [29:0] wr_data_out,
	output logic rd_stb_out
);
	initial begin
		wr_stb_out = 1'b0;
		wr_addr_out = 7'h7f;
		wr_data_out = 30'h2aaa_aaaa;
		rd_stb_out = 1'b0;
	end
	// idle lines carry the inverse so stale values never look valid
	task automatic write(input logic [6:0] a, input logic [29:0] d);
		@(negedge ref_clk_in);
		wr_stb_out = 1'b1;
		wr_addr_out = a;
		wr_data_out = d;
		@(negedge ref_clk_in);
		wr_stb_out = 1'b0;
		wr_addr_out = ~a;
		wr_data_out = ~d;
	endtask : write
	task automatic read(input logic [6:0] a, output logic [31:0] d);
		write(REG_ID_RST_RA, {23'h00_0000, a});
		rd_stb_out = 1'b1;
		@(negedge ref_clk_in);
		rd_stb_out = 1'b0;
		d = rd_data_in;
	endtask : read
	task automatic soft_reset(input logic hold);
		write(REG_ID_RST_RA, hold ? 30'h0000_0080 : 30'h0000_0000);
	endtask : soft_reset
endmodule : pfdrb_host

// ### test_pfdrb_bank.sv
// test_pfdrb_bank: self-checking bench for the pfd register bank
// assumes pfdrb_host drives strobes; bench drives pins on falling edges
`timescale 1ns/1ps
module test_pfdrb_bank;
	import pfdrb_pkg::*;
	localparam logic [23:0] TB_ID = 24'h5a_c3e1; // arbitrary value
	localparam int LIMIT = 10000;
	typedef struct {
		logic [6:0] a;
		logic [29:0] d;
		logic [31:0] e;
	} pfdrb_row_t;
	logic ref_clk_in, sys_rst_in, wr_stb, rd_stb, pin, ref_s, div_s;
	logic up_s, dn_s, xtal, gpo, ce, tick, dref, ddiv, drst, dup, ddn;
	logic ldu, ldn, gpoe, osld, tclk, dtclk, spoe, lock;
	logic [6:0] wa;
	logic [29:0] wd;
	logic [31:0] rd;
	logic [31:0] rv;
	logic slip, cp, gpp;
	logic [19:0] en;
	int fails = 0, checked = 0, cyc = 0, n;
	pfdrb_row_t rows [7] = '{
		'{REG_BLOCK_EN, 30'h3fff_ffff, 32'h000f_ffff},
		'{REG_BLOCK_EN, 30'h0000_0000, 32'h0000_0000},
		'{REG_REF_DIV, 30'h3fff_ffff, 32'h0000_3fff},
		'{REG_REF_DIV, 30'h0000_0001, 32'h0000_0001},
		'{REG_DET_SET, 30'h3fff_ffff, 32'h0000_0fff},
		'{REG_DET_SET, 30'h0000_0ccc, 32'h0000_0ccc},
		'{7'h05, 30'h1234_5678, 32'h0000_0000}
	};
	pfdrb_host i_pfdrb_host (.ref_clk_in(ref_clk_in), .rd_data_in(rd),
		.wr_stb_out(wr_stb), .wr_addr_out(wa), .wr_data_out(wd),
		.rd_stb_out(rd_stb));
	pfdrb_bank #(.CHIP_ID(TB_ID)) i_pfdrb_bank (.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in), .wr_stb_in(wr_stb), .wr_addr_in(wa),
		.wr_data_in(wd), .rd_stb_in(rd_stb), .chip_enable_pin_in(pin),
		.ref_in(ref_s), .div_in(div_s), .det_up_in(up_s), .det_dn_in(dn_s),
		.xtal_export_in(xtal), .gpo_data_in(gpo), .rd_data_out(rd),
		.chip_en_out(ce), .ref_tick_out(tick), .det_ref_out(dref),
		.det_div_out(ddiv), .det_rst_out(drst), .det_up_out(dup),
		.det_dn_out(ddn), .ld_up_out(ldu), .ld_dn_out(ldn),
		.slip_prevention_out(slip), .slip_prevention_oe_out(spoe),
		.cp_en_out(cp), .lock_indicator_out(lock), .oneshot_ld_en_out(osld),
		.general_purpose_pin_out(gpp), .general_purpose_pin_oe_out(gpoe),
		.test_clk_en_out(tclk), .div_test_clk_en_out(dtclk),
		.enables_out(en));
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == LIMIT) begin
			fails++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wt(input int k);
		repeat (k) @(negedge ref_clk_in);
	endtask : wt
	task automatic do_reset();
		sys_rst_in = 1'b1;
		wt(20);
		sys_rst_in = 1'b0;
	endtask : do_reset
	task automatic defaults();
		i_pfdrb_host.read(REG_BLOCK_EN, rv);
		chk(rv, {12'h000, EN_RST});
		i_pfdrb_host.read(REG_REF_DIV, rv);
		chk(rv, {18'h0_0000, RDIV_RST});
		i_pfdrb_host.read(REG_DET_SET, rv);
		chk(rv, {20'h0_0000, DS_RST});
		i_pfdrb_host.read(REG_ID_RST_RA, rv);
		chk(rv, {TB_ID, 8'h00});
		$display("test defaults done");
	endtask : defaults
	task automatic ce_case(input logic [19:0] e, input logic p, input logic x);
		i_pfdrb_host.write(REG_BLOCK_EN, {10'h000, e});
		pin = p;
		wt(2);
		chk({31'h0, ce}, {31'h0, x});
	endtask : ce_case
	task automatic det(input logic [11:0] s, input logic [3:0] x);
		i_pfdrb_host.write(REG_DET_SET, {18'h0_0000, s});
		wt(2);
		chk({28'h0, dup, ddn, ldu, ldn}, {28'h0, x});
	endtask : det
	initial begin
		sys_rst_in = 1'b1;
		pin = 1'b1;
		ref_s = 1'b0;
		div_s = 1'b0;
		up_s = 1'b0;
		dn_s = 1'b0;
		xtal = 1'b0;
		gpo = 1'b0;
		do_reset();
		defaults();
		foreach (rows[i]) begin
			i_pfdrb_host.write(rows[i].a, rows[i].d);
			i_pfdrb_host.read(rows[i].a, rv);
			chk(rv, rows[i].e);
		end
		$display("test rows done");
		ce_case(EN_RST, 1'b0, 1'b0);
		ce_case(EN_RST, 1'b1, 1'b1);
		ce_case(EN_RST | 20'h0_0001, 1'b0, 1'b1);
		ce_case(20'h3_fffd, 1'b1, 1'b0);
		i_pfdrb_host.write(REG_BLOCK_EN, {10'h000, EN_RST});
		wt(2);
		chk({26'h0, cp, gpoe, osld, tclk, dtclk, spoe},
			32'h0000_003d);
		i_pfdrb_host.write(REG_BLOCK_EN, 30'h0004_0003);
		wt(2);
		chk({26'h0, cp, gpoe, osld, tclk, dtclk, spoe},
			32'h0000_0002);
		chk({12'h000, en}, 32'h0004_0003);
		$display("test enables done");
		// detector needs its enable back before the gating checks
		i_pfdrb_host.write(REG_BLOCK_EN, {10'h000, EN_RST});
		ref_s = 1'b1;
		for (int i = 0; i < 4; i++) begin
			i_pfdrb_host.write(REG_DET_SET,
				{18'h0_0000, DS_RST[11:6], 2'(i), DS_RST[3:0]});
			wt(2);
			chk({30'h0, dref, ddiv},
				(32'h0000_0036 >> (2 * i)) & 32'h0000_0003);
		end
		up_s = 1'b1;
		det(DS_RST, 4'b1010);
		det(12'he8c, 4'b0101);
		det(12'h8cc, 4'b1000);
		xtal = 1'b1;
		i_pfdrb_host.write(REG_DET_SET, {18'h0_0000, DS_RST});
		wt(2);
		chk({31'h0, drst}, 32'h0000_0001);
		i_pfdrb_host.write(REG_DET_SET, 30'h0000_04cc);
		wt(2);
		chk({31'h0, drst}, 32'h0000_0000);
		xtal = 1'b0;
		$display("test detector done");
		i_pfdrb_host.write(REG_DET_SET, {18'h0_0000, DS_RST});
		i_pfdrb_host.write(REG_BLOCK_EN, {10'h000, EN_RST});
		up_s = 1'b0;
		wt(300);
		chk({31'h0, lock}, 32'h0000_0000);
		up_s = 1'b1;
		wt(1);
		up_s = 1'b0;
		wt(4);
		chk({31'h0, lock}, 32'h0000_0001);
		wt(300);
		chk({31'h0, lock}, 32'h0000_0000);
		i_pfdrb_host.write(REG_REF_DIV, 30'h0000_0003);
		wt(4);
		n = 0;
		repeat (30) begin
			wt(1);
			n += int'(tick);
		end
		chk(32'(n), 32'h0000_000a);
		$display("test watchdog divider done");
		i_pfdrb_host.write(REG_BLOCK_EN, 30'h0004_0003);
		i_pfdrb_host.soft_reset(1'b1);
		wt(2);
		chk({12'h000, en}, {12'h000, EN_RST});
		i_pfdrb_host.write(REG_BLOCK_EN, 30'h0000_0000);
		i_pfdrb_host.soft_reset(1'b0);
		wt(2);
		chk({12'h000, en}, {12'h000, EN_RST});
		i_pfdrb_host.read(REG_REF_DIV, rv);
		chk(rv, {18'h0_0000, RDIV_RST});
		$display("test soft reset done");
		i_pfdrb_host.write(REG_REF_DIV, 30'h0000_0123);
		do_reset();
		defaults();
		chk({31'h0, slip}, 32'h0000_0001);
		gpo = 1'b1;
		i_pfdrb_host.write(REG_DET_SET, 30'h0000_0dcc);
		wt(6);
		chk({29'h0, slip, lock, gpp}, 32'h0000_0003);
		$display("test slip done");
		final_report();
	end
endmodule : test_pfdrb_bank
